// ===== rtl/supply_monitor_pkg.sv
/*
  Package for the supply monitor controller: register offsets, field positions,
  reset values, delay constants and the carrier structs.
  Assumes a 125 MHz system clock and a byte-wide register port.
*/
package supply_monitor_pkg;

  // Clock rate
  localparam int CLK_MHZ = 125;

  // Register offsets on the plain register port
  localparam logic [3:0] OFS_DETECT_CTRL = 4'h0;
  localparam logic [3:0] OFS_GROUP2 = 4'h1;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h2;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h3;
  localparam logic [3:0] OFS_MISC = 4'h4;

  // Detect control fields
  localparam int POS_LOW_FLAG = 5;
  localparam int POS_ENABLE = 4;
  localparam int POS_LEVEL_LSB = 0;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h17;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Group 2 fields
  localparam int POS_LV_REQ = 4;
  localparam int POS_LV_EN = 0;
  localparam logic [7:0] GROUP2_WRITE_MASK = 8'h11;
  localparam logic [7:0] GROUP2_RESET = 8'h00;

  // Misc register: bit 0 global enable
  localparam int POS_GLOBAL_EN = 0;

  // Interrupt status bits
  localparam int EVT_LOW_RISE = 0;
  localparam int EVT_LV_REQ = 1;
  localparam int EVT_WAKE = 2;
  localparam logic [2:0] EVT_RESET = 3'h0;

  // Delays in ns, and derived cycle counts (least times round up)
  localparam int SETTLE_NS = 100;
  localparam int DETECT_NS = 100;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int DETECT_CYC = (DETECT_NS * CLK_MHZ + 999) / 1000;

  // Trip levels in tens of millivolts, indexed by the select code
  localparam logic [8:0] LEVEL_0 = 9'h0B4;
  localparam logic [8:0] LEVEL_1 = 9'h0C8;
  localparam logic [8:0] LEVEL_2 = 9'h0F0;
  localparam logic [8:0] LEVEL_3 = 9'h10E;
  localparam logic [8:0] LEVEL_4 = 9'h12C;
  localparam logic [8:0] LEVEL_5 = 9'h14A;
  localparam logic [8:0] LEVEL_6 = 9'h168;
  localparam logic [8:0] LEVEL_7 = 9'h190;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  // Analogue comparator link
  typedef struct packed {
    logic power_on;
    logic [2:0] level_sel;
    logic [8:0] level_code;
  } comparator_ctrl_type;

endpackage

// ===== rtl/pin_sync3.sv
/*
  Three-stage input synchroniser with agreement of stages two and three.
  Assumes the input comes from outside the clock domain.
*/
`timescale 1ns/1ps
module pin_sync3
  import supply_monitor_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic async_in,
  output logic level_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_state_type;

  sync_state_type cur_ff;
  sync_state_type nxt_cur;

  // Shift chain; level follows only when stages two and three agree
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.s1 = async_in;
    nxt_cur.s2 = cur_ff.s1;
    nxt_cur.s3 = cur_ff.s2;
    if (cur_ff.s2 == cur_ff.s3) begin
      nxt_cur.level = cur_ff.s3;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign level_out = cur_ff.level;

endmodule

// ===== rtl/delay_timer.sv
/*
  Down counter that reports done after a level has held for COUNT cycles.
  Assumes a synchronous active-high reset.
*/
`timescale 1ns/1ps
module delay_timer
  import supply_monitor_pkg::*;
#(
  parameter int COUNT = 13
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic run_in,
  output logic done_out
);

  localparam int W = $clog2(COUNT + 1);
  localparam logic [W-1:0] LOAD = W'(COUNT);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } timer_state_type;

  timer_state_type cur_ff;
  timer_state_type nxt_cur;

  // Reload while idle, count while running, hold done at zero
  always_comb begin
    nxt_cur = cur_ff;
    if (!run_in) begin
      nxt_cur.cnt = LOAD;
      nxt_cur.done = 1'b0;
    end else if (cur_ff.cnt > W'(1)) begin
      nxt_cur.cnt = cur_ff.cnt - W'(1);
    end else begin
      nxt_cur.cnt = '0;
      nxt_cur.done = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cur_ff <= '{cnt: LOAD, done: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign done_out = cur_ff.done;

endmodule

// ===== rtl/supply_monitor.sv
/*
  Supply monitor control: detect control register, group-2 multi-function
  interrupt register, event status with mask, wake and vector request.
  Assumes an analogue comparator beside it whose low output is asynchronous,
  and a processor that reports IDLE and SLEEP states as levels on its clock.
*/
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
module supply_monitor
  import supply_monitor_pkg::*;
#(
  parameter int DETECT_CYCLES = DETECT_CYC,
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic MCLK_IN,
  input wire logic RESET_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  input wire logic SUPPLY_LOW_IN,
  input wire logic IDLE_MODE_IN,
  input wire logic SLEEP_MODE_IN,
  output logic DETECT_POWER_OUT,
  output logic [2:0] LEVEL_SEL_OUT,
  output logic [8:0] LEVEL_CODE_OUT,
  output logic SETTLED_OUT,
  output logic GROUP2_REQ_OUT,
  output logic VECTOR_REQ_OUT,
  output logic WAKE_OUT,
  output logic IRQ_OUT
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] group2;
    logic global_en;
    logic [2:0] status;
    logic [2:0] mask;
    logic low_seen;
    logic [7:0] rdata;
    logic [8:0] level_code;
    logic power;
    logic group2_req;
    logic vector_req;
    logic wake;
  } mon_state_type;

  mon_state_type cur_ff;
  mon_state_type nxt_cur;
  reg_req_type req;
  comparator_ctrl_type cmp;
  logic low_sync;
  logic low_flag;
  logic detect_done;
  logic settle_done;
  logic power_now;
  logic req_rise;
  logic low_rise;

  // Bundle the register port
  assign req = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

  // Comparator output is a pin from the analogue side
  pin_sync3 low_sync_u (
    .clk_in(MCLK_IN),
    .reset_in(RESET_IN),
    .async_in(SUPPLY_LOW_IN),
    .level_out(low_sync)
  );

  // Detector on only when enabled and not in SLEEP
  assign power_now = cur_ff.ctrl[POS_ENABLE] & ~SLEEP_MODE_IN;
  // The flag is meaningful only while the detector is powered
  assign low_flag = low_sync & cur_ff.power;

  // Detection delay runs while the low flag holds
  delay_timer #(
    .COUNT(DETECT_CYCLES)
  ) detect_u (
    .clk_in(MCLK_IN),
    .reset_in(RESET_IN),
    .run_in(low_flag),
    .done_out(detect_done)
  );

  // Settling status, a guide for software polling
  delay_timer #(
    .COUNT(SETTLE_CYCLES)
  ) settle_u (
    .clk_in(MCLK_IN),
    .reset_in(RESET_IN),
    .run_in(cur_ff.power),
    .done_out(settle_done)
  );

  // Request sets once per low episode after the delay
  assign req_rise = detect_done & ~cur_ff.low_seen;
  assign low_rise = low_flag & ~cur_ff.low_seen & ~detect_done;

  // Trip level lookup
  function automatic logic [8:0] level_of(input logic [2:0] sel);
    logic [8:0] v;
    v = LEVEL_0;
    unique case (sel)
      3'h0: v = LEVEL_0;
      3'h1: v = LEVEL_1;
      3'h2: v = LEVEL_2;
      3'h3: v = LEVEL_3;
      3'h4: v = LEVEL_4;
      3'h5: v = LEVEL_5;
      3'h6: v = LEVEL_6;
      3'h7: v = LEVEL_7;
    endcase
    return v;
  endfunction

  // Register writes, event capture, reads and derived outputs
  always_comb begin
    logic [2:0] ev;
    logic [2:0] w1c;
    nxt_cur = cur_ff;
    ev = 3'h0;
    w1c = 3'h0;
    nxt_cur.power = power_now;
    nxt_cur.level_code = level_of(cur_ff.ctrl[2:0]);
    // Episode tracking: cleared when the flag falls, so toggles re-arm cleanly
    if (!low_flag) begin
      nxt_cur.low_seen = 1'b0;
    end else if (detect_done) begin
      nxt_cur.low_seen = 1'b1;
    end
    // Software writes; reserved control bits never store
    if (req.wr) begin
      unique case (req.addr)
        OFS_DETECT_CTRL: nxt_cur.ctrl = req.wdata & CTRL_WRITE_MASK;
        OFS_GROUP2: nxt_cur.group2 = req.wdata & GROUP2_WRITE_MASK;
        OFS_IRQ_STATUS: w1c = req.wdata[2:0];
        OFS_IRQ_MASK: nxt_cur.mask = req.wdata[2:0];
        OFS_MISC: nxt_cur.global_en = req.wdata[POS_GLOBAL_EN];
        default: ;
      endcase
    end
    // Hardware set of the request wins over a software clear
    if (req_rise) begin
      nxt_cur.group2[POS_LV_REQ] = 1'b1;
    end
    nxt_cur.group2_req = nxt_cur.group2[POS_LV_REQ] & nxt_cur.group2[POS_LV_EN];
    nxt_cur.vector_req = nxt_cur.group2_req & nxt_cur.global_en;
    // A pending request wakes from IDLE; a pre-set flag wakes at once
    nxt_cur.wake = IDLE_MODE_IN & nxt_cur.group2[POS_LV_REQ];
    // Sticky events, set wins over clear
    ev[EVT_LOW_RISE] = low_rise;
    ev[EVT_LV_REQ] = req_rise;
    ev[EVT_WAKE] = nxt_cur.wake & ~cur_ff.wake;
    nxt_cur.status = (cur_ff.status & ~w1c) | ev;
    // Read data stands in the cycle after the strobe
    nxt_cur.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        OFS_DETECT_CTRL: nxt_cur.rdata = (cur_ff.ctrl & CTRL_WRITE_MASK)
                                         | {2'h0, low_flag, 5'h00};
        OFS_GROUP2: nxt_cur.rdata = cur_ff.group2 & GROUP2_WRITE_MASK;
        OFS_IRQ_STATUS: nxt_cur.rdata = {5'h00, cur_ff.status};
        OFS_IRQ_MASK: nxt_cur.rdata = {5'h00, cur_ff.mask};
        OFS_MISC: nxt_cur.rdata = {6'h00, settle_done, cur_ff.global_en};
        default: nxt_cur.rdata = 8'h00;
      endcase
    end
  end

  // State register; every field clears on reset
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Comparator control bundle
  assign cmp = '{power_on: cur_ff.power, level_sel: cur_ff.ctrl[2:0],
                 level_code: cur_ff.level_code};

  // Outputs
  assign RDATA_OUT = cur_ff.rdata;
  assign DETECT_POWER_OUT = cmp.power_on;
  assign LEVEL_SEL_OUT = cmp.level_sel;
  assign LEVEL_CODE_OUT = cmp.level_code;
  assign SETTLED_OUT = settle_done;
  assign GROUP2_REQ_OUT = cur_ff.group2_req;
  assign VECTOR_REQ_OUT = cur_ff.vector_req;
  assign WAKE_OUT = cur_ff.wake;
  assign IRQ_OUT = |(cur_ff.status & cur_ff.mask);

endmodule

// ===== bench/supply_monitor_chk.sv
/*
  Port checker for the supply monitor controller.
  Assumes it is bound to every instance of supply_monitor.
*/
`timescale 1ns/1ps
module supply_monitor_chk (
  input wire logic MCLK_IN,
  input wire logic RESET_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic IDLE_MODE_IN,
  input wire logic SLEEP_MODE_IN,
  input wire logic DETECT_POWER_OUT,
  input wire logic [2:0] LEVEL_SEL_OUT,
  input wire logic [8:0] LEVEL_CODE_OUT,
  input wire logic SETTLED_OUT,
  input wire logic GROUP2_REQ_OUT,
  input wire logic VECTOR_REQ_OUT,
  input wire logic WAKE_OUT
);
  // Every check runs on the system clock and rests during reset
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RESET_IN);

  // Level code, register map, detector power and interrupt paths
  a_top_level: assert property (
    LEVEL_SEL_OUT == 3'h7 [*4] |-> LEVEL_CODE_OUT == 9'h190) else $error("top trip level wrong");
  a_reserved_zero: assert property (
    $past(RD_IN) && $past(ADDR_IN) == 4'h0 |-> RDATA_OUT[7:6] == 2'b00 && !RDATA_OUT[3])
    else $error("reserved control bits not zero");
  a_rdata_quiet: assert property (
    !$past(RD_IN) |-> RDATA_OUT == 8'h00) else $error("read data outside read slot");
  a_flag_unpowered: assert property (
    $past(RD_IN) && $past(ADDR_IN) == 4'h0 && !$past(DETECT_POWER_OUT)
    && !$past(DETECT_POWER_OUT, 2) |-> !RDATA_OUT[5]) else $error("low flag while unpowered");
  a_sleep_off: assert property (
    SLEEP_MODE_IN |=> !DETECT_POWER_OUT) else $error("detector powered in sleep");
  a_settle_off: assert property (
    !DETECT_POWER_OUT [*2] |-> !SETTLED_OUT) else $error("settled while unpowered");
  a_vector_cause: assert property (
    VECTOR_REQ_OUT |-> GROUP2_REQ_OUT || $past(GROUP2_REQ_OUT))
    else $error("vector without group request");
  a_wake_cause: assert property (
    WAKE_OUT |-> $past(IDLE_MODE_IN)) else $error("wake outside idle");
endmodule

bind supply_monitor supply_monitor_chk supply_monitor_chk_inst (.MCLK_IN, .RESET_IN, .ADDR_IN,
  .RD_IN, .RDATA_OUT, .IDLE_MODE_IN, .SLEEP_MODE_IN, .DETECT_POWER_OUT, .LEVEL_SEL_OUT,
  .LEVEL_CODE_OUT, .SETTLED_OUT, .GROUP2_REQ_OUT, .VECTOR_REQ_OUT, .WAKE_OUT);

// ===== bench/supply_comparator_model.sv
/*
  Behavioural analogue comparator: supply against trip level, both in 10 mV.
  Assumes the bench moves the supply; the output wanders while unpowered.
*/
`timescale 1ns/1ps
module supply_comparator_model (
  input wire logic clk_in,
  input wire logic power_in,
  input wire logic [8:0] level_in,
  input wire logic [8:0] vdd_in,
  output logic low_out = 1'b0
);
  // Powered: compare, slow supplies may toggle it unpowered: no stable value
  always @(posedge clk_in) begin
    if (power_in) begin
      low_out <= (vdd_in < level_in);
    end else begin
      low_out <= ~low_out;
    end
  end
endmodule

// ===== bench/supply_monitor_test.sv
/*
  Self-checking bench for supply_monitor with a comparator model.
  Assumes short detect and settle counts of 4 cycles.
*/
`timescale 1ns/1ps
module supply_monitor_test;
  import supply_monitor_pkg::*;
  localparam int DET = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic idle = 1'b0;
  logic sleep = 1'b0;
  logic [8:0] vdd = 9'h190;
  logic [15:0] lfsr = 16'd50107;
  logic low, power, settled, g2, vec, wake, irq;
  logic [7:0] rdata;
  logic [2:0] sel;
  logic [8:0] code;
  int error_cnt = 0;
  int comparisons = 0;
  int lv[8] = '{180, 200, 240, 270, 300, 330, 360, 400};
  int n, m;

  always #4 clk = ~clk;

  supply_monitor #(.DETECT_CYCLES(DET), .SETTLE_CYCLES(4)) supply_monitor_inst (
    .MCLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .SUPPLY_LOW_IN(low), .IDLE_MODE_IN(idle),
    .SLEEP_MODE_IN(sleep), .DETECT_POWER_OUT(power), .LEVEL_SEL_OUT(sel),
    .LEVEL_CODE_OUT(code), .SETTLED_OUT(settled), .GROUP2_REQ_OUT(g2),
    .VECTOR_REQ_OUT(vec), .WAKE_OUT(wake), .IRQ_OUT(irq));
  supply_comparator_model supply_comparator_model_inst (.clk_in(clk), .power_in(power),
    .level_in(code), .vdd_in(vdd), .low_out(low));

  // Checking and bus tasks; bus tasks start at a rising edge and end mid-cycle
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(16'(e), 16'(rdata));
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic test_done;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wreg(4'hF, 8'hFF);
    for (n = 0; n < 6; n++) rchk((n == 5) ? 4'hF : 4'(n), 8'h00);
    wreg(OFS_DETECT_CTRL, 8'hE8);
    rchk(OFS_DETECT_CTRL, 8'h00);
    for (n = 0; n < 8; n++) begin
      wreg(OFS_DETECT_CTRL, 8'hE0 | 8'(n));
      rchk(OFS_DETECT_CTRL, 8'(n));
      chk(16'(lv[n]), 16'(code));
      chk(16'(n), 16'(sel));
    end
    for (n = 0; n < 8; n++) begin
      lfsr = lfsr_next(lfsr);
      wreg(OFS_DETECT_CTRL, lfsr[7:0] | 8'h10);
      rchk(OFS_DETECT_CTRL, (lfsr[7:0] & 8'h07) | 8'h10);
    end
    // Undervoltage at the 2.7 V trip: flag, delayed request, vector, mask
    wreg(OFS_GROUP2, 8'h01);
    wreg(OFS_IRQ_MASK, 8'h02);
    wreg(OFS_DETECT_CTRL, 8'h13);
    tick(8);
    chk(16'h1, 16'(settled));
    chk(16'h0, 16'(irq));
    @(posedge clk);
    vdd <= 9'd250;
    m = 0;
    // Look at the request mid-cycle, never in the edge that launches it
    while (g2 !== 1'b1 && m < 40) begin
      tick(1);
      m++;
    end
    chk(16'h1, 16'(m >= DET + 3 && m < 40));
    if (m >= 40) test_done();
    rchk(OFS_DETECT_CTRL, 8'h33);
    rchk(OFS_GROUP2, 8'h11);
    chk(16'h1, 16'(irq));
    chk(16'h0, 16'(vec));
    wreg(OFS_MISC, 8'h01);
    tick(1);
    chk(16'h1, 16'(vec));
    rchk(OFS_MISC, 8'h03);
    // Pending request wakes from idle; clearing it lets idle stand
    @(posedge clk);
    idle <= 1'b1;
    tick(2);
    chk(16'h1, 16'(wake));
    wreg(OFS_GROUP2, 8'h01);
    tick(1);
    chk(16'h0, 16'(wake));
    // Software sets the request while already idle: wake follows at once, no group request
    wreg(OFS_GROUP2, 8'h10);
    tick(1);
    chk(16'h1, 16'(wake));
    chk(16'h0, 16'(g2));
    wreg(OFS_GROUP2, 8'h00);
    tick(1);
    chk(16'h0, 16'(wake));
    rchk(OFS_IRQ_STATUS, 8'h07);
    wreg(OFS_IRQ_STATUS, 8'h07);
    rchk(OFS_IRQ_STATUS, 8'h00);
    chk(16'h0, 16'(irq));
    // Sleep forces the detector off while the supply is still low
    @(posedge clk);
    idle <= 1'b0;
    sleep <= 1'b1;
    tick(2);
    chk(16'h0, 16'(power));
    rchk(OFS_DETECT_CTRL, 8'h13);
    test_done();
  end
endmodule
